/* File: design/event_status_pkg.sv */
// Package: offsets, bit positions and carriers for the event and status registers
package event_status_pkg;
    localparam int REG_ADDR_W = 8;
    localparam int REG_DATA_W = 8;
    localparam logic [REG_ADDR_W-1:0] EVENT_FLAGS_OFFSET = 8'h05;
    localparam logic [REG_ADDR_W-1:0] GLOBAL_STATUS_OFFSET = 8'h06;
    localparam logic [REG_DATA_W-1:0] EVENT_FLAGS_RESET = 8'h00;
    localparam logic [REG_DATA_W-1:0] READ_UNMAPPED = 8'h00;
    // Event flag bit positions
    localparam int FLAG_WDT_RESET = 7;
    localparam int FLAG_WATCHDOG_POWEROFF_FLAG = 6;
    localparam int FLAG_SW_COLD_RESET = 5;
    localparam int FLAG_SW_OFF = 4;
    localparam int FLAG_MANUAL_RESET = 3;
    localparam int FLAG_ANALOG_UV = 2;
    localparam int FLAG_SYSTEM_OV = 1;
    localparam int FLAG_THERMAL = 0;
    // Status bit positions
    localparam int STAT_METAL_ID = 7;
    localparam int STAT_BIAS_READY = 6;
    localparam int STAT_DROPOUT = 5;
    localparam int STAT_RESERVED = 4;
    localparam int STAT_ALARM_TWO = 3;
    localparam int STAT_ALARM_ONE = 2;
    localparam int STAT_ENABLE = 1;
    localparam int STAT_IRQ_DRIVE = 0;
    // Watchdog action and software control codes
    localparam logic WDT_ACTION_OFF = 1'b0;
    localparam logic WDT_ACTION_RESET = 1'b1;
    localparam logic [1:0] SW_CTRL_COLD_RESET = 2'h1;
    localparam logic [1:0] SW_CTRL_POWER_OFF = 2'h2;
    // Reset value of the neutral metal option id, arbitrary
    localparam logic METAL_ID_DEFAULT = 1'b0;
    localparam int SYNC_STAGES = 3;

    // Register access from the serial host
    typedef struct packed {
        logic rd;
        logic wr;
        logic [REG_ADDR_W-1:0] addr;
        logic [REG_DATA_W-1:0] wdata;
    } reg_req_type;

    // Raw event and level inputs from analog and control blocks
    typedef struct packed {
        logic watchdog_expired;
        logic manual_reset;
        logic analog_uv;
        logic system_ov;
        logic thermal_overload;
        logic bias_ready;
        logic regulator_dropout;
        logic thermal_alarm_two;
        logic thermal_alarm_one;
        logic irq_gate_drive;
    } analog_in_type;
endpackage : event_status_pkg

/* File: design/event_status_regs.sv */
// Event recorder flags and global status registers
// Functional notes
// [R1] Watchdog expiry with reset action sets flag bit 7.
// [R2] Watchdog expiry with power-off action sets flag bit 6.
// [R3] Software control write of 0b01 sets cold reset flag bit 5.
// [R4] Software control write of 0b10 sets power-off flag bit 4.
// [R5] Manual reset event sets flag bit 3.
// [R6] Analog supply undervoltage sets flag bit 2.
// [R7] System supply overvoltage sets flag bit 1.
// [R8] Thermal overload above 165C sets flag bit 0.
// [R9] Flags hold until read, then clear to zero.
// [R10] Status bit 7 shows the one-time-programmed metal option id.
// [R11] Status bit 6 shows main bias ready.
// [R12] Status bit 5 shows live regulator dropout.
// [R13] Status bits 3 and 2 show live thermal alarms two and one.
// [R14] Status bit 1 is one while debounced enable pin is low.
// [R15] Status bit 0 mirrors the unmasked interrupt gate drive.
// [R16] Software writes zero to status bit 4, ignores its read.
// [R17] Write data leaves flag and read-only status contents unchanged.
// [R18] Event in same cycle as flag read keeps flag set.
`timescale 1ns/10ps
module event_status_regs
    import event_status_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Register access, read data valid the cycle after rd
    input wire reg_req_type reg_req,
    output logic [REG_DATA_W-1:0] reg_rdata,
    // Watchdog action and software control field as held elsewhere
    input wire logic watchdog_action_select,
    input wire logic [1:0] software_power_control,
    // One-time-programmed identity
    input wire logic metal_option_id,
    // Debounced active-low enable pin level
    input wire logic enable_pin_n,
    // Analog detector inputs
    input wire analog_in_type analog_in
);
    localparam int N_SYNC = 10;

    logic [1:0] rst_sync_r;
    logic rst_n;
    logic [N_SYNC-1:0] raw_in;
    logic [N_SYNC-1:0] sync_in;
    logic wdt_s;
    logic manual_reset_flag_s;
    logic uv_s;
    logic ov_s;
    logic thermal_overload_flag_s;
    logic bias_s;
    logic regulator_dropout_status;
    logic al2_s;
    logic al1_s;
    logic irq_s;
    logic enable_pin_s;
    logic [4:0] edge_prev_r;
    logic [4:0] edge_now;
    logic [4:0] edge_rise;
    logic [REG_DATA_W-1:0] event_flags_r;
    logic [REG_DATA_W-1:0] event_flags_nxt;
    logic [REG_DATA_W-1:0] set_vec;
    logic [REG_DATA_W-1:0] status_view;
    logic sw_write;
    logic flags_read;
    logic metal_id_r;
    logic id_loaded_r;

    // Reset release through two flops
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            rst_sync_r <= 2'h0;
        else
            rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
    assign rst_n = rst_sync_r[1];

    assign raw_in = {analog_in.watchdog_expired, analog_in.manual_reset, analog_in.analog_uv,
                     analog_in.system_ov, analog_in.thermal_overload, analog_in.bias_ready,
                     analog_in.regulator_dropout, analog_in.thermal_alarm_two,
                     analog_in.thermal_alarm_one, analog_in.irq_gate_drive};

    level_sync #(
        .WIDTH(N_SYNC)
    ) u_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .async_in(raw_in),
        .sync_out(sync_in)
    );

    level_sync #(
        .WIDTH(1)
    ) u_enable_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .async_in(enable_pin_n),
        .sync_out(enable_pin_s)
    );

    assign {wdt_s, manual_reset_flag_s, uv_s, ov_s, thermal_overload_flag_s, bias_s, regulator_dropout_status, al2_s, al1_s, irq_s} = sync_in;

    // Rising edge of each event detector
    assign edge_now = {wdt_s, manual_reset_flag_s, uv_s, ov_s, thermal_overload_flag_s};

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            edge_prev_r <= 5'h00;
        else
            edge_prev_r <= edge_now;
    end
    assign edge_rise = edge_now & ~edge_prev_r;

    assign sw_write = reg_req.wr;
    assign flags_read = reg_req.rd && (reg_req.addr == EVENT_FLAGS_OFFSET);

    always_comb
    begin
        set_vec = '0;
        set_vec[FLAG_WDT_RESET] = edge_rise[4] && (watchdog_action_select == WDT_ACTION_RESET); // [R1]
        set_vec[FLAG_WATCHDOG_POWEROFF_FLAG] = edge_rise[4] && (watchdog_action_select == WDT_ACTION_OFF); // [R2]
        set_vec[FLAG_SW_COLD_RESET] = sw_write && (software_power_control == SW_CTRL_COLD_RESET); // [R3]
        set_vec[FLAG_SW_OFF] = sw_write && (software_power_control == SW_CTRL_POWER_OFF); // [R4]
        set_vec[FLAG_MANUAL_RESET] = edge_rise[3]; // [R5]
        set_vec[FLAG_ANALOG_UV] = edge_rise[2]; // [R6]
        set_vec[FLAG_SYSTEM_OV] = edge_rise[1]; // [R7]
        set_vec[FLAG_THERMAL] = edge_rise[0]; // [R8]
    end

    // Read clears, a simultaneous set wins; write data never alters flags
    always_comb
    begin
        event_flags_nxt = event_flags_r;
        if (flags_read)
            event_flags_nxt = EVENT_FLAGS_RESET; // [R9]
        event_flags_nxt = event_flags_nxt | set_vec; // [R18] [R17]
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            event_flags_r <= EVENT_FLAGS_RESET;
        else
            event_flags_r <= event_flags_nxt;
    end

    // Identity captured once after reset release
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            metal_id_r <= METAL_ID_DEFAULT;
            id_loaded_r <= 1'b0;
        end
        else if (!id_loaded_r)
        begin
            metal_id_r <= metal_option_id; // [R10]
            id_loaded_r <= 1'b1;
        end
    end

    always_comb
    begin
        status_view = '0; // [R16]
        status_view[STAT_METAL_ID] = metal_id_r; // [R10]
        status_view[STAT_BIAS_READY] = bias_s; // [R11]
        status_view[STAT_DROPOUT] = regulator_dropout_status; // [R12]
        status_view[STAT_ALARM_TWO] = al2_s; // [R13]
        status_view[STAT_ALARM_ONE] = al1_s; // [R13]
        status_view[STAT_ENABLE] = ~enable_pin_s; // [R14]
        status_view[STAT_IRQ_DRIVE] = irq_s; // [R15]
    end

    // Registered read data
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            reg_rdata <= READ_UNMAPPED;
        else if (reg_req.rd)
        begin
            unique case (reg_req.addr)
                EVENT_FLAGS_OFFSET: reg_rdata <= event_flags_r;
                GLOBAL_STATUS_OFFSET: reg_rdata <= status_view; // [R17]
                default: reg_rdata <= READ_UNMAPPED;
            endcase
        end
    end
endmodule : event_status_regs

/* File: design/level_sync.sv */
// Three-stage synchroniser, change accepted once stages two and three agree
`timescale 1ns/10ps
module level_sync
    import event_status_pkg::*;
#(
    parameter int WIDTH = 1
)
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1_r;
    logic [WIDTH-1:0] stage2_r;
    logic [WIDTH-1:0] stage3_r;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stage1_r <= '0;
            stage2_r <= '0;
            stage3_r <= '0;
        end
        else
        begin
            stage1_r <= async_in;
            stage2_r <= stage1_r;
            stage3_r <= stage2_r;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            sync_out <= '0;
        else
        begin
            for (int i = 0; i < WIDTH; i++)
            begin
                if (stage2_r[i] == stage3_r[i])
                    sync_out[i] <= stage3_r[i];
            end
        end
    end
endmodule : level_sync

/* File: verification/event_status_regs_monitor.sv */
// Port checker for the event flag and global status registers
`timescale 1ns/10ps
module event_status_regs_monitor
    import event_status_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Register access
    input wire reg_req_type reg_req,
    input wire logic [REG_DATA_W-1:0] reg_rdata,
    // Control, identity and detector inputs
    input wire logic watchdog_action_select,
    input wire logic [1:0] software_power_control,
    input wire logic metal_option_id,
    input wire logic enable_pin_n,
    input wire analog_in_type analog_in
);
    logic [10:0] prev_r;
    logic [3:0] quiet_r;
    logic pend_r;
    logic rf;
    logic live;
    assign rf = reg_req.rd && reg_req.addr == EVENT_FLAGS_OFFSET;
    assign live = reg_req.rd && reg_req.addr == GLOBAL_STATUS_OFFSET && quiet_r == 4'hF;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    // Cycles with detector inputs steady and no write
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            quiet_r <= '0;
        else if ({analog_in, enable_pin_n} != prev_r || reg_req.wr)
            quiet_r <= '0;
        else if (quiet_r != 4'hF)
            quiet_r <= quiet_r + 4'h1;
    end
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            prev_r <= '0;
        else
            prev_r <= {analog_in, enable_pin_n};
    end
    // Cold reset request not yet read back
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            pend_r <= 1'b0;
        else if (reg_req.wr && software_power_control == SW_CTRL_COLD_RESET)
            pend_r <= 1'b1;
        else if (rf)
            pend_r <= 1'b0;
    end
    AST_UNMAPPED: assert property (reg_req.rd && reg_req.addr != EVENT_FLAGS_OFFSET
        && reg_req.addr != GLOBAL_STATUS_OFFSET |=> reg_rdata == READ_UNMAPPED)
        else $error("unmapped read not zero");
    AST_CLEAR: assert property (rf ##3 rf && quiet_r == 4'hF |=> reg_rdata == 8'h00)
        else $error("flags not cleared by read");
    AST_COLD: assert property (rf && pend_r |=> reg_rdata[FLAG_SW_COLD_RESET])
        else $error("cold reset flag missing");
    AST_METAL: assert property (live |=> reg_rdata[STAT_METAL_ID] == $past(metal_option_id))
        else $error("metal id bit wrong");
    AST_BIAS: assert property (live |=> reg_rdata[STAT_BIAS_READY]
        == $past(analog_in.bias_ready))
        else $error("bias bit wrong");
    AST_DROP: assert property (live |=> reg_rdata[STAT_DROPOUT]
        == $past(analog_in.regulator_dropout))
        else $error("dropout bit wrong");
    AST_ALARM: assert property (live |=> reg_rdata[3:2]
        == $past({analog_in.thermal_alarm_two, analog_in.thermal_alarm_one}))
        else $error("alarm bits wrong");
    AST_ENABLE: assert property (live |=> reg_rdata[STAT_ENABLE] == !$past(enable_pin_n))
        else $error("enable bit wrong");
    AST_IRQ: assert property (live |=> reg_rdata[STAT_IRQ_DRIVE]
        == $past(analog_in.irq_gate_drive))
        else $error("gate drive bit wrong");
    cover property (rf && pend_r);
    cover property (live);
    cover property (rf ##3 rf && quiet_r == 4'hF);
endmodule : event_status_regs_monitor

bind event_status_regs event_status_regs_monitor MON (.core_clk(core_clk), .resetn(resetn),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .watchdog_action_select(watchdog_action_select),
    .software_power_control(software_power_control), .metal_option_id(metal_option_id),
    .enable_pin_n(enable_pin_n), .analog_in(analog_in));

/* File: verification/event_status_regs_test.sv */
// Self-checking bench for the event flag and global status registers
`timescale 1ns/10ps
module event_status_regs_test import event_status_pkg::*;;
    typedef struct packed {logic [9:0] a; logic s; logic w; logic [1:0] c; logic [7:0] e;} row_type;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    reg_req_type req = '0;
    logic [7:0] rdata;
    logic wsel = 1'b0;
    logic [1:0] ctrl = 2'h0;
    logic metal = 1'b1;
    logic en_n = 1'b1;
    analog_in_type ain = '0;
    int n_errors = 0;
    int n_tests = 0;
    logic [7:0] got;
    logic [7:0] acc;
    row_type rows [10] = '{'{10'h200, 1'b1, 1'b0, 2'h0, 8'h80}, '{10'h200, 1'b0, 1'b0, 2'h0, 8'h40},
        '{10'h000, 1'b0, 1'b1, 2'h1, 8'h20}, '{10'h000, 1'b0, 1'b1, 2'h2, 8'h10},
        '{10'h100, 1'b0, 1'b0, 2'h0, 8'h08}, '{10'h080, 1'b0, 1'b0, 2'h0, 8'h04},
        '{10'h040, 1'b0, 1'b0, 2'h0, 8'h02}, '{10'h020, 1'b0, 1'b0, 2'h0, 8'h01},
        '{10'h000, 1'b0, 1'b1, 2'h0, 8'h00}, '{10'h000, 1'b0, 1'b1, 2'h3, 8'h00}};
    event_status_regs DUT (.core_clk(core_clk), .resetn(resetn), .reg_req(req), .reg_rdata(rdata),
        .watchdog_action_select(wsel), .software_power_control(ctrl), .metal_option_id(metal),
        .enable_pin_n(en_n), .analog_in(ain));
    always #4 core_clk = ~core_clk;
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask : cyc
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
        n_tests++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        req.rd <= 1'b1;
        req.addr <= a;
        @(posedge core_clk);
        req.rd <= 1'b0;
        @(posedge core_clk);
        #1 d = rdata;
    endtask : rd
    task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string what);
        rd(a, got);
        check(what, e, got);
    endtask : rdc
    task automatic wrt(input logic [1:0] c, input logic [7:0] a);
        @(posedge core_clk);
        req.wr <= 1'b1;
        req.addr <= a;
        req.wdata <= 8'h00;
        ctrl <= c;
        @(posedge core_clk);
        req.wr <= 1'b0;
    endtask : wrt
    task automatic end_sim;
        $display("errors %0d, checks %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_sim
    initial
    begin
        #100000;
        n_errors++;
        end_sim();
    end
    initial
    begin
        cyc(16);
        resetn <= 1'b1;
        cyc(16);
        rdc(EVENT_FLAGS_OFFSET, EVENT_FLAGS_RESET, "flags at reset");
        rdc(GLOBAL_STATUS_OFFSET, 8'h80, "status at reset");
        foreach (rows[i])
        begin
            @(posedge core_clk);
            wsel <= rows[i].s;
            ain <= rows[i].a;
            if (rows[i].w)
                wrt(rows[i].c, EVENT_FLAGS_OFFSET);
            cyc(4);
            ain <= '0;
            cyc(16);
            rdc(EVENT_FLAGS_OFFSET, rows[i].e, "flags");
            rdc(EVENT_FLAGS_OFFSET, 8'h00, "flags reread");
        end
        @(posedge core_clk);
        ain <= 10'h015;
        en_n <= 1'b0;
        cyc(16);
        rdc(GLOBAL_STATUS_OFFSET, 8'hCB, "status live");
        ain <= 10'h00A;
        en_n <= 1'b1;
        cyc(16);
        rdc(GLOBAL_STATUS_OFFSET, 8'hA4, "status live");
        wrt(2'h0, GLOBAL_STATUS_OFFSET);
        rdc(GLOBAL_STATUS_OFFSET, 8'hA4, "status after write");
        rdc(8'h07, READ_UNMAPPED, "unmapped");
        @(posedge core_clk);
        ain <= 10'h020;
        req.rd <= 1'b1;
        req.addr <= EVENT_FLAGS_OFFSET;
        acc = '0;
        repeat (12)
        begin
            @(posedge core_clk);
            #1 acc = acc | rdata;
        end
        @(posedge core_clk);
        req.rd <= 1'b0;
        ain <= '0;
        rd(EVENT_FLAGS_OFFSET, got);
        check("flags during reads", 8'h01, acc | got);
        wrt(2'h1, EVENT_FLAGS_OFFSET);
        @(posedge core_clk);
        resetn <= 1'b0;
        cyc(2);
        resetn <= 1'b1;
        cyc(16);
        rdc(EVENT_FLAGS_OFFSET, EVENT_FLAGS_RESET, "flags after reset");
        rdc(GLOBAL_STATUS_OFFSET, 8'h80, "status after reset");
        end_sim();
    end
endmodule : event_status_regs_test
